/* core/ccm_mode_ctrl.sv */
/*
  Mode control, compare, capture and pin output for capture/compare
  modules 1 and 2 of a 16-bit counter array.
  Assumes the running count, the 8-to-11-bit PWM width and the SFR
  access strobes arrive synchronous to i_clk; the count itself lives outside.
  The pins are sampled once per clock, so a pulse shorter than a period
  may be missed; the first sample after reset only primes the edge detector.
  While the capture holds a nonzero count, the compare bytes read back the captured count.
*/
`timescale 1ns/1ps

module ccm_mode_ctrl #(
  parameter int NARROW_MAX = 11
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire ccm_pkg::ccm_sfr_s i_sfr,
  input  wire logic [15:0]      i_count,
  input  wire logic [1:0]       i_narrow_bits,
  input  wire logic [1:0]       i_pin_in,
  output logic [7:0]            o_rdata,
  output logic [1:0]            o_pin_out,
  output logic [1:0]            o_event_flag,
  output logic [1:0]            o_irq
);

  // Map the PWM width select (0..3 => 8..11 bits) to a mask of the count
  function automatic logic [15:0] narrow_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    narrow_mask = 16'h00ff;
      2'h1:    narrow_mask = 16'h01ff;
      2'h2:    narrow_mask = 16'h03ff;
      2'h3:    narrow_mask = 16'h07ff;
      default: narrow_mask = 16'h00ff;
    endcase
  endfunction

  // Decode a mode byte to the output function
  function automatic ccm_pkg::ccm_func_e decode_func(input logic [7:0] m);
    if (m[ccm_pkg::BIT_TOGGLE] && m[ccm_pkg::BIT_PWM]) begin
      decode_func = ccm_pkg::CCM_FREQ;
    end else if (m[ccm_pkg::BIT_PWM]) begin
      decode_func = m[ccm_pkg::BIT_WIDE_PWM] ? ccm_pkg::CCM_PWM_WIDE : ccm_pkg::CCM_PWM_NARW;
    end else if (m[ccm_pkg::BIT_TOGGLE]) begin
      decode_func = ccm_pkg::CCM_TOGGLE;
    end else begin
      decode_func = ccm_pkg::CCM_OFF;
    end
  endfunction

  // One SFR write strobe aimed at one address; shared by every register
  function automatic logic sfr_wr_hit(input ccm_pkg::ccm_sfr_s s, input logic [7:0] a);
    sfr_wr_hit = s.wr && (s.addr == a);
  endfunction

  // Per-module mode, compare and capture storage
  logic [1:0][7:0]  mode_q,    mode_d;
  logic [1:0][15:0] cmp_q,     cmp_d;
  logic [1:0][15:0] capt_q,    capt_d;

  // Pin side: polarity, alignment, flags, output levels and edge history
  logic [1:0]       pol_q,     pol_d;
  logic [1:0]       cen_q,     cen_d;
  logic [1:0]       flag_q,    flag_d;
  logic [1:0]       lvl_q,     lvl_d;
  logic [1:0]       pin_in_q,  pin_in_d;
  logic [1:0]       dir_q,     dir_d;
  logic [1:0]       pin_q,     pin_d;
  logic [1:0]       irq_q,     irq_d;

  // Read path, count history and edge-detect priming
  logic [7:0]       rdata_q,   rdata_d;
  logic [15:0]      prev_cnt_q, prev_cnt_d;
  logic             pin_live_q, pin_live_d;

  // Per-module events that feed the flag logic
  logic [1:0]       cap_ev;
  logic [1:0]       match;

  // Per-module compare, capture and output level
  for (genvar m = 0; m < ccm_pkg::NUM_MOD; m++) begin : g_mod
    logic [7:0]          md;
    ccm_pkg::ccm_func_e  fn;
    logic [15:0]         msk;
    logic [15:0]         cnt_eff;
    logic                rise;
    logic                fall;
    logic                ctr_on;
    logic                pwm_hi;
    logic [7:0]          cmp_lo_addr;
    logic [7:0]          cmp_hi_addr;
    logic [7:0]          mode_addr;

    // Mode decode and pin edge detection; edges count only once primed
    assign md          = mode_q[m];
    assign fn          = decode_func(md);
    assign msk         = (fn == ccm_pkg::CCM_PWM_WIDE) ? 16'hffff : narrow_mask(i_narrow_bits);
    assign cnt_eff     = i_count & msk;
    assign rise        = pin_live_q & ~pin_in_q[m] & i_pin_in[m];
    assign fall        = pin_live_q & pin_in_q[m] & ~i_pin_in[m];
    assign cap_ev[m]   = (rise & md[ccm_pkg::BIT_RISE_CAP]) | (fall & md[ccm_pkg::BIT_FALL_CAP]);
    assign match[m]    = md[ccm_pkg::BIT_COMPARE_EN] && (i_count == cmp_q[m]) && (i_count != prev_cnt_q);
    assign ctr_on      = cen_q[m] && (fn == ccm_pkg::CCM_PWM_NARW || fn == ccm_pkg::CCM_PWM_WIDE);
    assign mode_addr   = (m == 0) ? ccm_pkg::ADDR_MODE1 : ccm_pkg::ADDR_MODE2;
    assign cmp_lo_addr = (m == 0) ? ccm_pkg::ADDR_CMP1_LOW : ccm_pkg::ADDR_CMP2_LOW;
    assign cmp_hi_addr = (m == 0) ? ccm_pkg::ADDR_CMP1_HIGH : ccm_pkg::ADDR_CMP2_HIGH;

    // Center-aligned PWM compares on the folded count so the pulse sits mid-period
    always_comb begin
      logic [15:0] fold;
      fold = dir_q[m] ? (msk - cnt_eff) : cnt_eff;
      if (ctr_on) begin
        pwm_hi = md[ccm_pkg::BIT_COMPARE_EN] && (fold >= (cmp_q[m] & msk));
      end else begin
        pwm_hi = md[ccm_pkg::BIT_COMPARE_EN] && (cnt_eff >= (cmp_q[m] & msk));
      end
    end

    // Next mode, compare and capture storage for one module
    always_comb begin
      mode_d[m] = mode_q[m];
      cmp_d[m]  = cmp_q[m];
      capt_d[m] = capt_q[m];
      if (sfr_wr_hit(i_sfr, mode_addr)) begin
        mode_d[m] = i_sfr.wdata;
      end
      if (sfr_wr_hit(i_sfr, cmp_lo_addr)) begin
        cmp_d[m][7:0]                      = i_sfr.wdata;
        mode_d[m][ccm_pkg::BIT_COMPARE_EN] = 1'b0;
      end
      if (sfr_wr_hit(i_sfr, cmp_hi_addr)) begin
        cmp_d[m][15:8]                     = i_sfr.wdata;
        mode_d[m][ccm_pkg::BIT_COMPARE_EN] = 1'b1;
      end
      if (cap_ev[m]) begin
        capt_d[m] = i_count;
      end
    end

    // Next output level and center-alignment direction for one module
    always_comb begin
      lvl_d[m]    = lvl_q[m];
      dir_d[m]    = dir_q[m];
      pin_in_d[m] = i_pin_in[m];
      // Direction flips at the ends of the masked range for center alignment
      if (cnt_eff == msk) begin
        dir_d[m] = 1'b1;
      end else if (cnt_eff == 16'h0000) begin
        dir_d[m] = 1'b0;
      end
      case (fn)
        ccm_pkg::CCM_TOGGLE,
        ccm_pkg::CCM_FREQ: begin
          if (match[m]) begin
            lvl_d[m] = ~lvl_q[m];
          end
        end
        ccm_pkg::CCM_PWM_NARW,
        ccm_pkg::CCM_PWM_WIDE: begin
          lvl_d[m] = pwm_hi;
        end
        ccm_pkg::CCM_OFF: begin
          lvl_d[m] = lvl_q[m];
        end
        default: begin
          lvl_d[m] = lvl_q[m];
        end
      endcase
    end

    // Event flag: hardware set wins over a software clear in the same cycle
    always_comb begin
      flag_d[m] = flag_q[m];
      if (sfr_wr_hit(i_sfr, ccm_pkg::ADDR_EVENT) && !i_sfr.wdata[m]) begin
        flag_d[m] = 1'b0;
      end
      if ((match[m] && md[ccm_pkg::BIT_MATCH_FLAG]) || cap_ev[m]) begin
        flag_d[m] = 1'b1;
      end
    end

    // Interrupt and pin follow the next flag, level and polarity, so a polarity
    // write reaches the pin at the same edge that stores it
    always_comb begin
      irq_d[m] = flag_d[m] & md[ccm_pkg::BIT_EVENT_IRQ];
      pin_d[m] = lvl_d[m] ^ pol_d[m];
    end
  end

  // A nonzero capture overrides the shared compare/capture storage as software sees it
  function automatic logic [7:0] capt_sel(input int m, input logic hi);
    logic [15:0] v;
    v = (capt_q[m] != ccm_pkg::RST_CAPTURE) ? capt_q[m] : cmp_q[m];
    capt_sel = hi ? v[15:8] : v[7:0];
  endfunction

  // Shared registers and read mux
  always_comb begin
    pol_d   = pol_q;
    cen_d   = cen_q;
    rdata_d = rdata_q;
    if (sfr_wr_hit(i_sfr, ccm_pkg::ADDR_POLARITY)) begin
      pol_d = i_sfr.wdata[2:1];
    end
    if (sfr_wr_hit(i_sfr, ccm_pkg::ADDR_CENTER)) begin
      cen_d = i_sfr.wdata[2:1];
    end
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        ccm_pkg::ADDR_MODE1:     rdata_d = mode_q[0];
        ccm_pkg::ADDR_MODE2:     rdata_d = mode_q[1];
        ccm_pkg::ADDR_CMP1_LOW:  rdata_d = capt_sel(0, 1'b0);
        ccm_pkg::ADDR_CMP1_HIGH: rdata_d = capt_sel(0, 1'b1);
        ccm_pkg::ADDR_CMP2_LOW:  rdata_d = capt_sel(1, 1'b0);
        ccm_pkg::ADDR_CMP2_HIGH: rdata_d = capt_sel(1, 1'b1);
        ccm_pkg::ADDR_POLARITY:  rdata_d = {5'h00, pol_q, 1'b0};
        ccm_pkg::ADDR_CENTER:    rdata_d = {5'h00, cen_q, 1'b0};
        ccm_pkg::ADDR_EVENT:     rdata_d = {6'h00, flag_q};
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  // Count history for the no-repeat match; the priming bit rises one edge
  // after reset so that a pin already high is not taken for a rising edge
  always_comb begin
    prev_cnt_d = i_count;
    pin_live_d = 1'b1;
  end

  // Mode, compare and capture storage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= {ccm_pkg::NUM_MOD{ccm_pkg::RST_MODE}};
      cmp_q  <= {ccm_pkg::NUM_MOD{ccm_pkg::RST_CMP}};
      capt_q <= {ccm_pkg::NUM_MOD{ccm_pkg::RST_CAPTURE}};
    end else begin
      mode_q <= mode_d;
      cmp_q  <= cmp_d;
      capt_q <= capt_d;
    end
  end

  // Pin side state: polarity, alignment, flags, levels and edge history
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pol_q    <= 2'h0;
      cen_q    <= 2'h0;
      flag_q   <= 2'h0;
      lvl_q    <= 2'h0;
      pin_in_q <= 2'h0;
      dir_q    <= 2'h0;
      pin_q    <= 2'h0;
      irq_q    <= 2'h0;
    end else begin
      pol_q    <= pol_d;
      cen_q    <= cen_d;
      flag_q   <= flag_d;
      lvl_q    <= lvl_d;
      pin_in_q <= pin_in_d;
      dir_q    <= dir_d;
      pin_q    <= pin_d;
      irq_q    <= irq_d;
    end
  end

  // Read data, count history and edge-detect priming
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q    <= 8'h00;
      prev_cnt_q <= 16'h0000;
      pin_live_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      prev_cnt_q <= prev_cnt_d;
      pin_live_q <= pin_live_d;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_pin_out    = pin_q;
  assign o_event_flag = flag_q;
  assign o_irq        = irq_q;

endmodule

/* core/ccm_pkg.sv */
/*
  Shared constants and carriers for the counter-array capture/compare
  mode-control block (modules 1 and 2).
  Assumes an 8-bit special-function-register port with byte addresses.
*/
package ccm_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_MODE1     = 8'hdb;
  localparam logic [7:0] ADDR_MODE2     = 8'hdc;
  localparam logic [7:0] ADDR_CMP1_LOW  = 8'he9;
  localparam logic [7:0] ADDR_CMP1_HIGH = 8'hea;
  localparam logic [7:0] ADDR_CMP2_LOW  = 8'heb;
  localparam logic [7:0] ADDR_CMP2_HIGH = 8'hec;
  localparam logic [7:0] ADDR_POLARITY  = 8'h96;
  localparam logic [7:0] ADDR_CENTER    = 8'h9e;
  localparam logic [7:0] ADDR_EVENT     = 8'hd9;

  // Mode register field positions
  localparam int BIT_WIDE_PWM   = 7;
  localparam int BIT_COMPARE_EN = 6;
  localparam int BIT_RISE_CAP   = 5;
  localparam int BIT_FALL_CAP   = 4;
  localparam int BIT_MATCH_FLAG = 3;
  localparam int BIT_TOGGLE     = 2;
  localparam int BIT_PWM        = 1;
  localparam int BIT_EVENT_IRQ  = 0;

  // Reset values
  localparam logic [7:0]  RST_MODE    = 8'h00;
  localparam logic [15:0] RST_CMP     = 16'h0000;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;

  // Number of modules handled here
  localparam int NUM_MOD = 2;

  // Software register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccm_sfr_s;

  // Output function of a module, decoded from its mode bits
  typedef enum logic [2:0] {
    CCM_OFF      = 3'b000,
    CCM_TOGGLE   = 3'b001,
    CCM_PWM_NARW = 3'b010,
    CCM_PWM_WIDE = 3'b011,
    CCM_FREQ     = 3'b100
  } ccm_func_e;

endpackage

/* tb/ccm_mode_ctrl_checker.sv */
/* Port checker for ccm_mode_ctrl, bound to each instance.
   Assumes the mode bytes change only through the SFR port. */
`timescale 1ns/1ps
module ccm_mode_ctrl_checker (
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire ccm_pkg::ccm_sfr_s i_sfr,
  input wire logic [1:0]        i_pin_in,
  input wire logic [7:0]        o_rdata,
  input wire logic [1:0]        o_event_flag,
  input wire logic [1:0]        o_irq
);
  logic [7:0] m1_q, m2_q;
  wire        c1 = (m1_q[6] && m1_q[3]) || m1_q[5] || m1_q[4];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Shadow mode bytes; compare-byte writes move bit 6 as a side effect
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      m1_q <= 8'h00;
      m2_q <= 8'h00;
    end else if (i_sfr.wr) begin
      case (i_sfr.addr)
        ccm_pkg::ADDR_MODE1:     m1_q <= i_sfr.wdata;
        ccm_pkg::ADDR_MODE2:     m2_q <= i_sfr.wdata;
        ccm_pkg::ADDR_CMP1_LOW:  m1_q[6] <= 1'b0;
        ccm_pkg::ADDR_CMP1_HIGH: m1_q[6] <= 1'b1;
        ccm_pkg::ADDR_CMP2_LOW:  m2_q[6] <= 1'b0;
        ccm_pkg::ADDR_CMP2_HIGH: m2_q[6] <= 1'b1;
        default: ;
      endcase
    end
  end
  sequence s_wr(a); i_sfr.wr && i_sfr.addr == a; endsequence
  sequence s_rd(a); i_sfr.rd && i_sfr.addr == a; endsequence
  property p_rd1; s_rd(ccm_pkg::ADDR_MODE1) |=> o_rdata == $past(m1_q); endproperty
  a_rd1: assert property (p_rd1) else $error("mode1 readback wrong");
  property p_rd2; s_rd(ccm_pkg::ADDR_MODE2) |=> o_rdata == $past(m2_q); endproperty
  a_rd2: assert property (p_rd2) else $error("mode2 readback wrong");
  property p_low; s_wr(ccm_pkg::ADDR_CMP1_LOW) ##2 s_rd(ccm_pkg::ADDR_MODE1) |=> !o_rdata[6]; endproperty
  a_low: assert property (p_low) else $error("low byte kept compare on");
  property p_high; s_wr(ccm_pkg::ADDR_CMP2_HIGH) ##2 s_rd(ccm_pkg::ADDR_MODE2) |=> o_rdata[6]; endproperty
  a_high: assert property (p_high) else $error("high byte left compare off");
  property p_rise; $rose(i_pin_in[0]) && m1_q[5] && $past(i_nrst) |-> ##[1:2] o_event_flag[0]; endproperty
  a_rise: assert property (p_rise) else $error("rising capture missed");
  property p_irq_on; o_event_flag[0] && m1_q[0] && !(i_sfr.wr && i_sfr.addr == ccm_pkg::ADDR_MODE1)
    |-> ##[0:1] o_irq[0]; endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked flag gave no irq");
  property p_irq_off; !m2_q[0] && !$past(m2_q[0]) |-> !o_irq[1]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked flag gave irq");
  property p_cause; $rose(o_event_flag[0]) |-> $past(c1) || $past(c1, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag set with no enabled source");
endmodule
bind ccm_mode_ctrl ccm_mode_ctrl_checker ccm_mode_ctrl_checker_i (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_sfr(i_sfr), .i_pin_in(i_pin_in), .o_rdata(o_rdata), .o_event_flag(o_event_flag), .o_irq(o_irq));

/* tb/ccm_pin_partner.sv */
/* Far-side driver of the two module pins.
   Assumes the bench sets the wanted level away from the falling edge. */
`timescale 1ns/1ps
module ccm_pin_partner (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_level,
  input  wire logic       i_slow,
  output logic [1:0]      o_pin = 2'h0
);
  logic [1:0] lag_q = 2'h0;
  // Drive at the falling edge; the slow path answers one cycle late
  always @(negedge i_clk) begin
    lag_q <= i_level;
    o_pin <= i_slow ? lag_q : i_level;
  end
endmodule

/* tb/tb_top.sv */
/* Self-checking bench for ccm_mode_ctrl.
   Assumes the pin partner and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
  logic              i_clk = 1'b0;
  logic              i_nrst = 1'b0;
  ccm_pkg::ccm_sfr_s i_sfr = '0;
  logic [15:0]       i_count = 16'h0000;
  logic [1:0]        i_narrow_bits = 2'h0;
  logic [1:0]        lvl = 2'h0;
  logic              slow = 1'b0;
  logic [1:0]        i_pin_in, o_pin_out, o_event_flag, o_irq;
  logic [7:0]        o_rdata;
  logic [15:0]       r;
  logic              p0;
  int                n_errors = 0;
  int                num_checks = 0;
  ccm_mode_ctrl ccm_mode_ctrl_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_sfr(i_sfr), .i_count(i_count),
    .i_narrow_bits(i_narrow_bits), .i_pin_in(i_pin_in), .o_rdata(o_rdata), .o_pin_out(o_pin_out),
    .o_event_flag(o_event_flag), .o_irq(o_irq));
  ccm_pin_partner ccm_pin_partner_i (.i_clk(i_clk), .i_level(lvl), .i_slow(slow), .o_pin(i_pin_in));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // Mode byte expected after a compare-byte write moves bit 6
  function automatic logic [7:0] cen(input logic [7:0] m, input logic s);
    return {m[7], s, m[5:0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle strobe; for a read d is the expected byte
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_sfr = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clk);
    i_sfr = '0;
    if (!w) chk("rdata", d, o_rdata);
  endtask
  // Four cycles cover detection even on the slow path
  task automatic pins(input logic [1:0] l, input logic s);
    @(posedge i_clk);
    lvl = l;
    slow = s;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    r = 16'($urandom(32'hb75c));
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    acc(0, ccm_pkg::ADDR_MODE1, 8'h00);
    // Random mode bytes on both modules, then each compare-byte side effect
    for (int i = 0; i < 6; i++) begin
      r = 16'($urandom());
      i_narrow_bits = r[9:8];
      acc(1, ccm_pkg::ADDR_MODE1 + 8'(i % 2), r[7:0]);
      acc(0, ccm_pkg::ADDR_MODE1 + 8'(i % 2), r[7:0]);
      acc(1, ccm_pkg::ADDR_CMP1_LOW + 8'(2 * (i % 2)), r[15:8]);
      acc(0, ccm_pkg::ADDR_MODE1 + 8'(i % 2), cen(r[7:0], 1'b0));
      acc(1, ccm_pkg::ADDR_CMP1_HIGH + 8'(2 * (i % 2)), r[15:8]);
      acc(0, ccm_pkg::ADDR_MODE1 + 8'(i % 2), cen(r[7:0], 1'b1));
    end
    // Rising capture on module 1 with its interrupt unmasked
    acc(1, ccm_pkg::ADDR_MODE2, 8'h00);
    acc(1, ccm_pkg::ADDR_MODE1, 8'h21);
    acc(1, ccm_pkg::ADDR_EVENT, 8'h00);
    i_count = r | 16'h0101;
    pins(2'b01, 1'b0);
    chk("flag", 8'(2'b01), 8'(o_event_flag));
    chk("irq", 8'(2'b01), 8'(o_irq));
    acc(0, ccm_pkg::ADDR_CMP1_LOW, i_count[7:0]);
    acc(0, ccm_pkg::ADDR_CMP1_HIGH, i_count[15:8]);
    // Both edges on module 1, falling only on module 2, slow partner
    acc(1, ccm_pkg::ADDR_MODE1, 8'h30);
    acc(1, ccm_pkg::ADDR_MODE2, 8'h10);
    acc(1, ccm_pkg::ADDR_EVENT, 8'h00);
    pins(2'b10, 1'b1);
    chk("flag", 8'(2'b01), 8'(o_event_flag));
    pins(2'b00, 1'b1);
    chk("flag", 8'(2'b11), 8'(o_event_flag));
    chk("irq", 8'h00, 8'(o_irq));
    // A match flags and toggles only with the compare enable on
    acc(1, ccm_pkg::ADDR_CMP1_LOW, 8'h34);
    acc(1, ccm_pkg::ADDR_CMP1_HIGH, 8'h12);
    for (int e = 0; e < 2; e++) begin
      acc(1, ccm_pkg::ADDR_MODE1, e ? 8'h4c : 8'h0c);
      acc(1, ccm_pkg::ADDR_EVENT, 8'h00);
      i_count = 16'h1233;
      repeat (2) @(negedge i_clk);
      p0 = o_pin_out[0];
      i_count = 16'h1234;
      repeat (3) @(negedge i_clk);
      chk("match", 8'(e), 8'(o_event_flag[0]));
      chk("toggle", 8'(p0 ^ e[0]), 8'(o_pin_out[0]));
    end
    // Polarity must reach the pin without a counter event
    acc(1, ccm_pkg::ADDR_MODE1, 8'h00);
    @(negedge i_clk);
    p0 = o_pin_out[0];
    acc(1, ccm_pkg::ADDR_POLARITY, 8'h02);
    chk("polarity", 8'(!p0), 8'(o_pin_out[0]));
    // Wide PWM sees the whole compare word, 8-bit PWM its low byte only
    for (int w = 0; w < 2; w++) begin
      acc(1, ccm_pkg::ADDR_CMP1_LOW, 8'h00);
      acc(1, ccm_pkg::ADDR_CMP1_HIGH, 8'h80);
      acc(1, ccm_pkg::ADDR_MODE1, w ? 8'hc2 : 8'h42);
      i_narrow_bits = 2'h0;
      i_count = 16'h0010;
      repeat (3) @(negedge i_clk);
      p0 = o_pin_out[0];
      i_count = 16'hfff0;
      repeat (3) @(negedge i_clk);
      chk("pwm", 8'(p0 ^ w[0]), 8'(o_pin_out[0]));
    end
    // Center alignment folds the count on the way down; edge alignment does not
    acc(1, ccm_pkg::ADDR_POLARITY, 8'h00);
    acc(1, ccm_pkg::ADDR_CMP1_LOW, 8'h80);
    acc(1, ccm_pkg::ADDR_CMP1_HIGH, 8'h00);
    acc(1, ccm_pkg::ADDR_MODE1, 8'h42);
    for (int c = 0; c < 2; c++) begin
      acc(1, ccm_pkg::ADDR_CENTER, c ? 8'h02 : 8'h00);
      i_count = 16'h00ff;
      repeat (2) @(negedge i_clk);
      i_count = 16'h0010;
      repeat (3) @(negedge i_clk);
      chk("center", 8'(c), 8'(o_pin_out[0]));
    end
    // Frequency output toggles once per match and ignores the PWM level
    acc(1, ccm_pkg::ADDR_CENTER, 8'h00);
    acc(1, ccm_pkg::ADDR_CMP1_LOW, 8'h34);
    acc(1, ccm_pkg::ADDR_CMP1_HIGH, 8'h12);
    acc(1, ccm_pkg::ADDR_MODE1, 8'h46);
    i_count = 16'h1233;
    repeat (2) @(negedge i_clk);
    p0 = o_pin_out[0];
    i_count = 16'h1234;
    @(negedge i_clk);
    i_count = 16'h1233;
    repeat (3) @(negedge i_clk);
    chk("freq", 8'(!p0), 8'(o_pin_out[0]));
    finish_test();
  end
endmodule
